// ---- terminal_command_decoder.v ----
// terminal command decoder: filtered terminals into run commands,
// reference index, ramp set, motor set and braking requests
// assumes raw terminals are asynchronous; settings are static-ish levels
`include "terminal_command_decoder_defs.vh"

module terminal_command_decoder #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input  wire                 clk_sys,
  input  wire                 rst_b,
  // raw terminals from switches and push-buttons
  input  wire                 input_first,
  input  wire                 input_second,
  input  wire                 input_third,
  input  wire                 switch_a,
  input  wire                 switch_b,
  input  wire                 switch_c,
  input  wire                 switch_d,
  input  wire                 ramp_sel_first,
  input  wire                 ramp_sel_second,
  input  wire                 motor_sel,
  input  wire                 decel_brake_in,
  input  wire                 direct_brake_in,
  input  wire                 run_time_clear_in,
  // settings and motor-control feedback
  input  wire [`MODE_W-1:0]   terminal_command_mode,
  input  wire [`FILT_W-1:0]   input_filter_time,
  input  wire                 run_time_clear_en,
  input  wire [`PCT_W-1:0]    preset_percent,
  input  wire [`FREQ_W-1:0]   maximum_frequency_setting,
  input  wire [`FREQ_W-1:0]   output_frequency,
  input  wire [`FREQ_W-1:0]   brake_start_frequency,
  // commands and selections
  output reg                  forward_run,
  output reg                  reverse_run,
  output reg  [3:0]           reference_index,
  output reg  [`FREQ_W-1:0]   frequency_reference,
  output reg  [1:0]           ramp_set,
  output reg                  motor_second,
  output reg                  decel_request,
  output reg                  dc_brake_active,
  output reg                  run_time_clear,
  output reg  [`MODE_W-1:0]   active_mode
);

  // brake sequencer states, one-hot
  localparam [2:0] BR_IDLE  = 3'b001;
  localparam [2:0] BR_DECEL = 3'b010;
  localparam [2:0] BR_HOLD  = 3'b100;

  // last count of the tick divider
  localparam integer TICK_LAST = TICK_CYCLES - 1;

  // internal state
  reg              rst_m;
  reg              rst_q;
  reg  [17:0]      tick_cnt;
  reg              tick;
  reg  [`NIN-1:0]  sync_1;
  reg  [`NIN-1:0]  sync_2;
  reg  [`NIN-1:0]  sync_3;
  reg  [`NIN-1:0]  filt;
  reg  [`NIN-1:0]  filt_d;
  reg  [`FILT_W-1:0] filt_cnt [0:`NIN-1];
  reg              run_latch;
  reg              dir_latch;
  reg  [2:0]       br_state;
  reg  [2:0]       next_br_state;
  reg              next_fwd;
  reg              next_rev;
  reg  [`FILT_W-1:0] filt_lim;
  // decode nets
  wire [`NIN-1:0]  raw_in;
  wire [`NIN-1:0]  rise;
  wire [`PROD_W-1:0] prod;
  wire [`PROD_W-1:0] prod_div;
  wire             en3;
  wire             stopped;
  integer          i;

  // terminal vector in filtered-bit order
  assign raw_in = {run_time_clear_in, direct_brake_in, decel_brake_in,
                   motor_sel, ramp_sel_second, ramp_sel_first,
                   switch_d, switch_c, switch_b, switch_a,
                   input_third, input_second, input_first};

  // rising edges of the filtered levels
  assign rise    = filt & ~filt_d;

  // three-wire enable and stopped state
  assign en3     = filt[`IN_THIRD];
  assign stopped = ~forward_run & ~reverse_run;

  // preset scaling: 1000 (100 %) maps onto the maximum frequency
  assign prod     = preset_percent * maximum_frequency_setting;
  assign prod_div = prod / `PCT_FULL;

  // reset release through two flip-flops
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_m <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_q <= rst_m;
    end
  end

  // 1 ms tick enable for the filter counters
  always @(posedge clk_sys or negedge rst_q) begin
    if (!rst_q) begin
      tick_cnt <= 18'h00000;
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_LAST[17:0]) begin
      tick_cnt <= 18'h00000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 18'h00001;
      tick     <= 1'b0;
    end
  end

  // three-stage synchroniser on every terminal
  always @(posedge clk_sys or negedge rst_q) begin
    if (!rst_q) begin
      sync_1 <= {`NIN{1'b0}};
      sync_2 <= {`NIN{1'b0}};
      sync_3 <= {`NIN{1'b0}};
    end else begin
      sync_1 <= raw_in;
      sync_2 <= sync_1;
      sync_3 <= sync_2;
    end
  end

  // clamp the filter time to its 1000 ms ceiling
  always @* begin
    if (input_filter_time > `FILT_MAX_MS)
      filt_lim = `FILT_MAX_MS;
    else
      filt_lim = input_filter_time;
  end

  // per-terminal debounce: level accepted after stable filter time
  always @(posedge clk_sys or negedge rst_q) begin
    if (!rst_q) begin
      filt   <= {`NIN{1'b0}};
      filt_d <= {`NIN{1'b0}};
      for (i = 0; i < `NIN; i = i + 1)
        filt_cnt[i] <= {`FILT_W{1'b0}};
    end else begin
      filt_d <= filt;
      for (i = 0; i < `NIN; i = i + 1) begin
        if (sync_2[i] != sync_3[i] || sync_3[i] == filt[i]) begin
          filt_cnt[i] <= {`FILT_W{1'b0}}; // unsettled or no change
        end else if (filt_cnt[i] >= filt_lim) begin
          filt[i]     <= sync_3[i];
          filt_cnt[i] <= {`FILT_W{1'b0}};
        end else if (tick) begin
          filt_cnt[i] <= filt_cnt[i] + {{(`FILT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // mode setting adopted only while stopped
  always @(posedge clk_sys or negedge rst_q) begin
    if (!rst_q)
      active_mode <= `MODE_DEF;
    else if (stopped)
      active_mode <= terminal_command_mode;
  end

  // run latch for the three-wire modes
  always @(posedge clk_sys or negedge rst_q) begin
    if (!rst_q) begin
      run_latch <= 1'b0;
      dir_latch <= 1'b0;
    end else if (!en3) begin
      run_latch <= 1'b0;
    end else if (active_mode == `MODE_THREE_1) begin
      if (rise[`IN_FIRST] && !rise[`IN_SECOND]) begin
        run_latch <= 1'b1;
        dir_latch <= 1'b0;
      end else if (rise[`IN_SECOND] && !rise[`IN_FIRST]) begin
        run_latch <= 1'b1;
        dir_latch <= 1'b1;
      end
    end else if (active_mode == `MODE_THREE_2) begin
      if (rise[`IN_FIRST])
        run_latch <= 1'b1;
      dir_latch <= filt[`IN_SECOND];
    end else begin
      run_latch <= 1'b0;
    end
  end

  // run and direction decode per mode
  always @* begin
    next_fwd = 1'b0;
    next_rev = 1'b0;
    case (active_mode)
      `MODE_TWO_1: begin
        next_fwd = filt[`IN_FIRST] & ~filt[`IN_SECOND];
        next_rev = ~filt[`IN_FIRST] & filt[`IN_SECOND];
      end
      `MODE_TWO_2: begin
        next_fwd = filt[`IN_FIRST] & ~filt[`IN_SECOND];
        next_rev = filt[`IN_FIRST] & filt[`IN_SECOND];
      end
      `MODE_THREE_1, `MODE_THREE_2: begin
        next_fwd = en3 & run_latch & ~dir_latch;
        next_rev = en3 & run_latch & dir_latch;
      end
      default: begin
        next_fwd = 1'b0;
        next_rev = 1'b0;
      end
    endcase
  end

  // brake sequencer transitions
  always @* begin
    next_br_state = br_state;
    case (br_state)
      BR_IDLE: begin
        if (filt[`IN_DIRECT_BRAKE])
          next_br_state = BR_HOLD;
        else if (rise[`IN_DECEL_BRAKE])
          next_br_state = BR_DECEL;
      end
      BR_DECEL: begin
        if (filt[`IN_DIRECT_BRAKE])
          next_br_state = BR_HOLD;
        else if (!filt[`IN_DECEL_BRAKE])
          next_br_state = BR_IDLE;
        else if (output_frequency <= brake_start_frequency)
          next_br_state = BR_HOLD;
      end
      BR_HOLD: begin
        if (!filt[`IN_DIRECT_BRAKE] && !filt[`IN_DECEL_BRAKE])
          next_br_state = BR_IDLE;
      end
      default: next_br_state = BR_IDLE;
    endcase
  end

  // brake state and its outputs
  always @(posedge clk_sys or negedge rst_q) begin
    if (!rst_q) begin
      br_state        <= BR_IDLE;
      decel_request   <= 1'b0;
      dc_brake_active <= 1'b0;
    end else begin
      br_state        <= next_br_state;
      decel_request   <= next_br_state == BR_DECEL;
      dc_brake_active <= next_br_state == BR_HOLD;
    end
  end

  // registered command and selection outputs
  always @(posedge clk_sys or negedge rst_q) begin
    if (!rst_q) begin
      forward_run         <= 1'b0;
      reverse_run         <= 1'b0;
      reference_index     <= 4'h0;
      frequency_reference <= {`FREQ_W{1'b0}};
      ramp_set            <= 2'h0;
      motor_second        <= 1'b0;
      run_time_clear      <= 1'b0;
    end else begin
      forward_run     <= next_fwd;
      reverse_run     <= next_rev;
      reference_index <= filt[`IN_MREF_HI:`IN_MREF_LO];
      // 100 % (1000) maps onto the maximum frequency
      frequency_reference <= prod_div[`FREQ_W-1:0];
      ramp_set <= {filt[`IN_RAMP_2], filt[`IN_RAMP_1]};
      motor_second <= filt[`IN_MOTOR];
      // one-cycle clear pulse on the rising edge
      run_time_clear <= rise[`IN_RT_CLEAR] & run_time_clear_en;
    end
  end

endmodule // terminal_command_decoder

// ---- terminal_command_decoder_asserts.sv ----
// checker for the terminal command decoder outputs
// bound into the top module, sees only its ports
module terminal_command_decoder_asserts (
  input wire        clk_sys,
  input wire        rst_b,
  input wire        run_time_clear_en,
  input wire [10:0] preset_percent,
  input wire [15:0] maximum_frequency_setting,
  input wire [15:0] output_frequency,
  input wire [15:0] brake_start_frequency,
  input wire        forward_run,
  input wire        reverse_run,
  input wire [15:0] frequency_reference,
  input wire        decel_request,
  input wire        dc_brake_active,
  input wire        run_time_clear,
  input wire [1:0]  active_mode
);
  reg [2:0] up;
  // cycles since release, so the scaling check skips the sync stages
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
  end
  run_excl_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !(forward_run && reverse_run)) else $error("both directions commanded");
  mode_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $changed(active_mode) |-> !$past(forward_run) && !$past(reverse_run))
    else $error("mode changed while running");
  clear_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    run_time_clear |=> !run_time_clear) else $error("clear pulse too long");
  clear_enable_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    run_time_clear |-> $past(run_time_clear_en)) else $error("clear while disabled");
  freq_scale_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (up == 3'h7) |-> frequency_reference ==
    ($past(preset_percent) * $past(maximum_frequency_setting)) / 1000)
    else $error("reference scaling wrong");
  brake_handover_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    decel_request && (output_frequency <= brake_start_frequency) |=>
    dc_brake_active && !decel_request) else $error("no handover to braking");
  brake_excl_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !(decel_request && dc_brake_active)) else $error("ramp and brake together");
  reset_zero_a: assert property (@(posedge clk_sys)
    !rst_b |-> active_mode == 2'h0 && !forward_run && !reverse_run)
    else $error("outputs not cleared in reset");
endmodule // terminal_command_decoder_asserts

bind terminal_command_decoder terminal_command_decoder_asserts chk (.clk_sys, .rst_b,
  .run_time_clear_en, .preset_percent, .maximum_frequency_setting, .output_frequency,
  .brake_start_frequency, .forward_run, .reverse_run, .frequency_reference,
  .decel_request, .dc_brake_active, .run_time_clear, .active_mode);

// ---- terminal_command_decoder_defs.vh ----
// constants for the terminal command decoder
// assumes a 200 MHz system clock and 1 ms filter ticks
`ifndef TERMINAL_COMMAND_DECODER_DEFS_VH
`define TERMINAL_COMMAND_DECODER_DEFS_VH

// clock rate and filter tick period
`define CLK_MHZ          200
`define TICK_TIME_US     1000
`define TICK_CYCLES      (`TICK_TIME_US * `CLK_MHZ)

// filter time in ms: range 0..1000, default 10
`define FILT_W           10
`define FILT_MAX_MS      10'd1000
`define FILT_DEF_MS      10'd10

// terminal command mode codes
`define MODE_W           2
`define MODE_TWO_1       2'd0
`define MODE_TWO_2       2'd1
`define MODE_THREE_1     2'd2
`define MODE_THREE_2     2'd3
`define MODE_DEF         2'd0

// filtered input vector positions
`define NIN              13
`define IN_FIRST         0
`define IN_SECOND        1
`define IN_THIRD         2
`define IN_MREF_LO       3
`define IN_MREF_HI       6
`define IN_RAMP_1        7
`define IN_RAMP_2        8
`define IN_MOTOR         9
`define IN_DECEL_BRAKE   10
`define IN_DIRECT_BRAKE  11
`define IN_RT_CLEAR      12

// preset scaling: percent in 0.1 % steps, 1000 is 100 %
`define PCT_W            11
`define PCT_FULL         27'd1000
`define FREQ_W           16
`define PROD_W           27

`endif

// ---- terminal_command_decoder_test.sv ----
// self-checking bench for the terminal command decoder
// assumes the contact model in front of the raw terminals
`include "terminal_command_decoder_defs.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module terminal_command_decoder_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [1:0] m; logic [12:0] t; logic f, r;
    logic [3:0] i; logic [1:0] s; logic mo, dc;} row_t;
  reg clk_sys, rst_b, run_time_clear_en;
  reg [1:0] terminal_command_mode;
  reg [9:0] input_filter_time;
  reg [10:0] preset_percent;
  reg [15:0] maximum_frequency_setting, output_frequency, brake_start_frequency;
  reg [12:0] want;
  wire [12:0] raw;
  wire forward_run, reverse_run, motor_second, decel_request, dc_brake_active;
  wire run_time_clear;
  wire [3:0] reference_index;
  wire [1:0] ramp_set, active_mode;
  wire [15:0] frequency_reference;
  integer failures, cmp_count, cyc, pulses, n;
  row_t rows [13] = '{'{0, 13'h001, 1, 0, 0, 0, 0, 0}, '{0, 13'h002, 0, 1, 0, 0, 0, 0},
    '{0, 13'h003, 0, 0, 0, 0, 0, 0}, '{1, 13'h001, 1, 0, 0, 0, 0, 0},
    '{1, 13'h003, 0, 1, 0, 0, 0, 0}, '{1, 13'h002, 0, 0, 0, 0, 0, 0},
    '{0, 13'h078, 0, 0, 15, 0, 0, 0}, '{0, 13'h048, 0, 0, 9, 0, 0, 0},
    '{0, 13'h030, 0, 0, 6, 0, 0, 0}, '{0, 13'h080, 0, 0, 0, 1, 0, 0},
    '{0, 13'h100, 0, 0, 0, 2, 0, 0}, '{0, 13'h380, 0, 0, 0, 3, 1, 0},
    '{0, 13'h800, 0, 0, 0, 0, 0, 1}};
  terminal_contacts contacts (.clk_sys, .want, .raw);
  terminal_command_decoder #(.TICK_CYCLES(4)) DUT (.clk_sys, .rst_b,
    .input_first(raw[0]), .input_second(raw[1]), .input_third(raw[2]),
    .switch_a(raw[3]), .switch_b(raw[4]), .switch_c(raw[5]), .switch_d(raw[6]),
    .ramp_sel_first(raw[7]), .ramp_sel_second(raw[8]), .motor_sel(raw[9]),
    .decel_brake_in(raw[10]), .direct_brake_in(raw[11]), .run_time_clear_in(raw[12]),
    .terminal_command_mode, .input_filter_time, .run_time_clear_en, .preset_percent,
    .maximum_frequency_setting, .output_frequency, .brake_start_frequency, .forward_run,
    .reverse_run, .reference_index, .frequency_reference, .ramp_set, .motor_second,
    .decel_request, .dc_brake_active, .run_time_clear, .active_mode);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task step(input integer k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task wrap_up;
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // contacts held long enough to pass the filter, then run state checked
  task press(input [12:0] t, input f, input r);
    want = t;
    step(40);
    `CHK({forward_run, reverse_run}, {f, r})
  endtask
  // hang guard and clear pulse counter
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (run_time_clear === 1'b1) pulses <= pulses + 1;
    if (cyc == 6000) begin
      failures++;
      wrap_up;
    end
  end
  initial begin
    {failures, cmp_count, cyc, pulses} = 0;
    rst_b = 1'b1;
    want = 13'h0000;
    terminal_command_mode = 2'h0;
    input_filter_time = 10'd3;
    run_time_clear_en = 1'b1;
    preset_percent = 11'd1000;
    maximum_frequency_setting = 16'h1234;
    output_frequency = 16'h0100;
    brake_start_frequency = 16'h0010;
    #1 rst_b = 1'b0;
    step(12);
    rst_b = 1'b1;
    step(3);
    `CHK({active_mode, forward_run, reverse_run}, 4'h0)
    foreach (rows[k]) begin
      press(13'h000, 0, 0);
      terminal_command_mode = rows[k].m;
      step(8);
      press(rows[k].t, rows[k].f, rows[k].r);
      `CHK(active_mode, rows[k].m)
      `CHK(reference_index, rows[k].i)
      `CHK({ramp_set, motor_second}, {rows[k].s, rows[k].mo})
      `CHK({decel_request, dc_brake_active}, {1'b0, rows[k].dc})
    end
    press(13'h000, 0, 0);
    want = 13'h001;
    step(2);
    want = 13'h000;
    repeat (14) begin
      step(1);
      `CHK({forward_run, reverse_run}, 2'b00)
    end
    press(13'h000, 0, 0);
    terminal_command_mode = 2'h2;
    step(8);
    press(13'h004, 0, 0);
    press(13'h005, 1, 0);
    press(13'h004, 1, 0);
    press(13'h006, 0, 1);
    press(13'h004, 0, 1);
    press(13'h000, 0, 0);
    terminal_command_mode = 2'h3;
    step(8);
    press(13'h004, 0, 0);
    press(13'h005, 1, 0);
    press(13'h006, 0, 1);
    press(13'h004, 1, 0);
    press(13'h000, 0, 0);
    terminal_command_mode = 2'h0;
    step(8);
    want = 13'h001;
    step(10);
    `CHK({forward_run, reverse_run}, 2'b00)
    press(13'h001, 1, 0);
    terminal_command_mode = 2'h1;
    step(8);
    `CHK(active_mode, 2'h0)
    press(13'h000, 0, 0);
    `CHK(active_mode, 2'h1)
    press(13'h400, 0, 0);
    `CHK({decel_request, dc_brake_active}, 2'b10)
    output_frequency = 16'h0010;
    step(2);
    `CHK({decel_request, dc_brake_active}, 2'b01)
    press(13'h000, 0, 0);
    `CHK({decel_request, dc_brake_active}, 2'b00)
    for (n = 1; n >= 0; n--) begin
      run_time_clear_en = n[0];
      pulses = 0;
      press(13'h1000, 0, 0);
      press(13'h000, 0, 0);
      `CHK(pulses, n)
    end
    `CHK(frequency_reference, 16'h1234)
    preset_percent = 11'd500;
    step(3);
    `CHK(frequency_reference, 16'h091A)
    press(13'h001, 1, 0);
    rst_b = 1'b0;
    step(2);
    `CHK({active_mode, forward_run, reverse_run, dc_brake_active}, 5'h00)
    `CHK({reference_index, ramp_set, motor_second}, 7'h00)
    rst_b = 1'b1;
    step(3);
    press(13'h001, 1, 0);
    `CHK(active_mode, 2'h1)
    wrap_up;
  end
endmodule // terminal_command_decoder_test

// ---- terminal_contacts.sv ----
// contact model: every change of a wanted level chatters before settling
// assumes the bench sets the wanted levels just after clk_sys rises
module terminal_contacts (
  input  wire        clk_sys,
  input  wire [12:0] want,
  output reg  [12:0] raw
);
  timeunit 1ns;
  timeprecision 100ps;
  reg [12:0] held;
  reg [12:0] mask;
  reg [1:0]  bounce;
  initial begin
    raw = 13'h0000;
    held = 13'h0000;
    mask = 13'h0000;
    bounce = 2'h0;
  end
  // changed bits toggle each cycle for three cycles, then rest
  always @(posedge clk_sys) begin
    if (want != held) begin
      held <= want;
      mask <= want ^ held;
      bounce <= 2'h3;
      raw <= want;
    end else if (bounce != 2'h0) begin
      bounce <= bounce - 2'h1;
      raw <= raw ^ mask;
    end else raw <= held;
  end
endmodule // terminal_contacts
